// ### rtl/tfr_pkg.sv
// constants, types and register map for the shared parity / frame reference pin
//
// Overview of operation
// [R1] Pin is parity input when bus enabled, frame reference only when framer enabled.
// [R2] One parity option covers the eight telecom data bits, even or odd.
// [R3] Other option covers data bits plus payload and frame start flags.
// [R4] Coverage and sense come from the interface control byte register.
// [R5] Loop or async timing: pulse reference output high one bit before frame start.
// [R6] Pulse-locked timing: source pulses reference input with each frame's first bit.
// [R7] Pulse-locked timing: generated frames align to received reference pulses.
// [R8] Generator bypassed: reference function inactive, no pulses driven or used.
// [R9] Output mode: one pulse per generated frame, low at every other bit.
package tfr_pkg;

    // register indices; byte address is four times the index
    localparam logic [11:0] IDX_ICB1   = 12'h013A;
    localparam logic [11:0] IDX_CFG    = 12'h0140;
    localparam logic [11:0] IDX_STATUS = 12'h0141;
    localparam logic [1:0]  ADDR_LSB   = 2'h0;

    // interface control byte fields
    localparam int          ICB_COVER_BIT = 0;
    localparam int          ICB_ODD_BIT   = 1;
    localparam logic [7:0]  ICB_RESET     = 8'h00;
    localparam logic [7:0]  ICB_WMASK     = 8'h03;

    // configuration register fields
    localparam int          CFG_TBUS_EN_BIT  = 0;
    localparam int          CFG_FRAMER_BIT   = 1;
    localparam int          CFG_BYPASS_BIT   = 2;
    localparam int          CFG_TIMING_LSB   = 4;
    localparam int          CFG_LEN_LSB      = 16;
    localparam logic [15:0] FRAME_LEN_RESET  = 16'h0040;

    // status register fields
    localparam int          ST_ROLE_LSB      = 0;
    localparam int          ST_MISMATCH_BIT  = 2;
    localparam int          ST_CNT_LSB       = 16;

    // timing mode codes held in the configuration register
    localparam logic [1:0]  TM_LOOP   = 2'h0;
    localparam logic [1:0]  TM_ASYNC  = 2'h1;
    localparam logic [1:0]  TM_PULSE  = 2'h2;

    // ahb encodings
    localparam logic [2:0]  HSIZE_WORD = 3'h2;
    localparam logic        HRESP_OKAY = 1'b0;

    typedef enum logic [1:0] {
        ROLE_IDLE,
        ROLE_PARITY,
        ROLE_REF_OUT,
        ROLE_REF_IN
    } tfr_role_e;

    typedef struct packed {
        logic [7:0] data;
        logic       payload;
        logic       frame_start;
    } tfr_tbus_s;

    typedef struct packed {
        logic [15:0] frame_len;
        logic [1:0]  timing;
        logic        gen_bypass;
        logic        framer_en;
        logic        tbus_en;
    } tfr_cfg_s;

endpackage : tfr_pkg

// ### rtl/tfr_frame_gen.sv
// tributary frame generator bit counter with reference pulse in and out
`timescale 1ns/100ps
`default_nettype none
module tfr_frame_gen #(
    parameter int LEN_W = 16
) (
    input  wire logic             hclk,         // system clock, one tributary bit
    input  wire logic             hresetn,      // async reset, active low
    input  wire logic             run,          // generator active for this pin
    input  wire logic             lock_mode,    // pulse-locked timing
    input  wire logic             ref_in,       // reference pulse from pin
    input  wire logic [LEN_W-1:0] frame_len,    // bits per frame
    output logic      [LEN_W-1:0] bit_cnt_q,    // index of the current bit
    output logic                  frame_start,  // current bit is frame bit 0
    output logic                  ref_pulse_q   // reference pulse to pin
);
    logic [LEN_W-1:0] cnt_d;
    logic             pulse_d;
    logic             locked_ref;

    always_comb begin
        locked_ref = run && lock_mode && ref_in;
        if (!run) begin
            // [R8] bypass clears counter
            cnt_d = '0;
        end else if (locked_ref) begin
            // [R7] realign on pulse
            cnt_d = LEN_W'(1);
        end else if (bit_cnt_q >= frame_len - LEN_W'(1)) begin
            cnt_d = '0;
        end else begin
            cnt_d = bit_cnt_q + LEN_W'(1);
        end
        // [R5] pulse one bit early
        // [R9] once per frame
        pulse_d = run && !lock_mode && (cnt_d == frame_len - LEN_W'(1));
        frame_start = locked_ref || (run && bit_cnt_q == '0);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bit_cnt_q   <= '0;
            ref_pulse_q <= 1'b0;
        end else begin
            bit_cnt_q   <= cnt_d;
            ref_pulse_q <= pulse_d;
        end
    end
endmodule : tfr_frame_gen
`default_nettype wire

// ### rtl/tfr_pin_top.sv
// shared parity input / frame reference pin with ahb-lite registers
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
module tfr_pin_top (
    input  wire logic             hclk,              // 25 MHz clock
    input  wire logic             hresetn,           // async reset, active low
    input  wire logic             hsel,              // ahb slave select
    input  wire logic [31:0]      haddr,             // ahb address
    input  wire logic [1:0]       htrans,            // ahb transfer type
    input  wire logic             hwrite,            // ahb write
    input  wire logic [2:0]       hsize,             // ahb size
    input  wire logic [31:0]      hwdata,            // ahb write data
    input  wire logic             hready,            // ahb bus ready
    output logic                  hreadyout,         // ahb slave ready
    output logic [31:0]           hrdata,            // ahb read data
    output logic                  hresp,             // ahb response
    input  wire tfr_pkg::tfr_tbus_s telecom_tx_bus,  // telecom data and flags
    input  wire logic             tributary_data_in, // tributary bit stream
    input  wire logic             frame_ref_pin_i,   // shared pin level in
    output logic                  frame_ref_pin_o,   // shared pin drive
    output logic                  frame_ref_pin_oe,  // shared pin enable
    output logic                  parity_mismatch_q, // parity check failed
    output logic                  trib_frame_start,  // frame bit 0 now
    output logic                  trib_data_q        // tributary bit, registered
);
    localparam int LEN_W = 16;

    // bus state
    logic        wr_pend_q, wr_pend_d;
    logic [11:0] wr_idx_q, wr_idx_d;
    logic [31:0] rdata_q, rdata_d;
    logic [11:0] addr_idx;
    logic        addr_ok;
    logic        take;

    // register state
    logic [7:0]        icb_q, icb_d;
    tfr_pkg::tfr_cfg_s cfg_q, cfg_d;

    // pin state
    tfr_pkg::tfr_role_e role_q, role_d;
    logic               mism_d;
    logic               trib_d;
    logic               expect_par;

    logic [LEN_W-1:0] bit_cnt;
    logic             ref_pulse;
    logic             gen_run;
    logic             gen_lock;

    // even sense: pin makes total ones even
    function automatic logic parity_of(input tfr_pkg::tfr_tbus_s b,
                                       input logic [7:0] icb);
        logic p;
        p = ^b.data;
        if (icb[tfr_pkg::ICB_COVER_BIT]) begin
            p = p ^ b.payload ^ b.frame_start;
        end
        return icb[tfr_pkg::ICB_ODD_BIT] ? ~p : p;
    endfunction : parity_of

    assign addr_idx  = haddr[13:2];
    assign addr_ok   = (haddr[1:0] == tfr_pkg::ADDR_LSB) && (haddr[31:14] == '0);
    assign take      = hsel && htrans[1] && hready;
    assign hreadyout = 1'b1;
    assign hresp     = tfr_pkg::HRESP_OKAY;
    assign hrdata    = rdata_q;

    // ---------------- bus slave ----------------
    always_comb begin
        wr_pend_d = 1'b0;
        wr_idx_d  = wr_idx_q;
        rdata_d   = rdata_q;
        if (take) begin
            wr_pend_d = hwrite && addr_ok && (hsize == tfr_pkg::HSIZE_WORD);
            wr_idx_d  = addr_idx;
            rdata_d   = '0;
            if (!hwrite && addr_ok) begin
                unique case (addr_idx)
                    tfr_pkg::IDX_ICB1: begin
                        rdata_d[7:0] = icb_q;
                    end
                    tfr_pkg::IDX_CFG: begin
                        rdata_d[tfr_pkg::CFG_TBUS_EN_BIT] = cfg_q.tbus_en;
                        rdata_d[tfr_pkg::CFG_FRAMER_BIT]  = cfg_q.framer_en;
                        rdata_d[tfr_pkg::CFG_BYPASS_BIT]  = cfg_q.gen_bypass;
                        rdata_d[tfr_pkg::CFG_TIMING_LSB +: 2] = cfg_q.timing;
                        rdata_d[tfr_pkg::CFG_LEN_LSB +: LEN_W] = cfg_q.frame_len;
                    end
                    tfr_pkg::IDX_STATUS: begin
                        rdata_d[tfr_pkg::ST_ROLE_LSB +: 2]    = role_q;
                        rdata_d[tfr_pkg::ST_MISMATCH_BIT]     = parity_mismatch_q;
                        rdata_d[tfr_pkg::ST_CNT_LSB +: LEN_W] = bit_cnt;
                    end
                    default: begin
                        rdata_d = '0;
                    end
                endcase
            end
        end
    end

    // ---------------- registers ----------------
    always_comb begin
        icb_d = icb_q;
        cfg_d = cfg_q;
        if (wr_pend_q) begin
            unique case (wr_idx_q)
                tfr_pkg::IDX_ICB1: begin
                    // [R4] coverage and sense
                    icb_d = hwdata[7:0] & tfr_pkg::ICB_WMASK;
                end
                tfr_pkg::IDX_CFG: begin
                    cfg_d.tbus_en    = hwdata[tfr_pkg::CFG_TBUS_EN_BIT];
                    cfg_d.framer_en  = hwdata[tfr_pkg::CFG_FRAMER_BIT];
                    cfg_d.gen_bypass = hwdata[tfr_pkg::CFG_BYPASS_BIT];
                    cfg_d.timing     = hwdata[tfr_pkg::CFG_TIMING_LSB +: 2];
                    cfg_d.frame_len  = hwdata[tfr_pkg::CFG_LEN_LSB +: LEN_W];
                end
                default: begin
                    icb_d = icb_q;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= '0;
            rdata_q   <= '0;
            icb_q     <= tfr_pkg::ICB_RESET;
            cfg_q     <= '{frame_len: tfr_pkg::FRAME_LEN_RESET,
                           timing:    tfr_pkg::TM_LOOP,
                           default:   1'b0};
        end else begin
            wr_pend_q <= wr_pend_d;
            wr_idx_q  <= wr_idx_d;
            rdata_q   <= rdata_d;
            icb_q     <= icb_d;
            cfg_q     <= cfg_d;
        end
    end

    // ---------------- pin role and parity ----------------
    always_comb begin
        // [R1] bus enable has priority
        if (cfg_q.tbus_en) begin
            role_d = tfr_pkg::ROLE_PARITY;
        // [R8] bypassed generator idles pin
        end else if (!cfg_q.framer_en || cfg_q.gen_bypass) begin
            role_d = tfr_pkg::ROLE_IDLE;
        end else if (cfg_q.timing == tfr_pkg::TM_PULSE) begin
            role_d = tfr_pkg::ROLE_REF_IN;
        end else if (cfg_q.timing == tfr_pkg::TM_LOOP || cfg_q.timing == tfr_pkg::TM_ASYNC) begin
            role_d = tfr_pkg::ROLE_REF_OUT;
        end else begin
            // unused timing code: keep pin quiet
            role_d = tfr_pkg::ROLE_IDLE;
        end

        // [R2] [R3] expected parity bit
        expect_par = parity_of(telecom_tx_bus, icb_q);
        mism_d     = (role_q == tfr_pkg::ROLE_PARITY) && (frame_ref_pin_i != expect_par);
        trib_d     = tributary_data_in;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            role_q            <= tfr_pkg::ROLE_IDLE;
            parity_mismatch_q <= 1'b0;
            trib_data_q       <= 1'b0;
        end else begin
            role_q            <= role_d;
            parity_mismatch_q <= mism_d;
            trib_data_q       <= trib_d;
        end
    end

    assign gen_run  = (role_q == tfr_pkg::ROLE_REF_OUT) || (role_q == tfr_pkg::ROLE_REF_IN);
    assign gen_lock = (role_q == tfr_pkg::ROLE_REF_IN);

    // [R6] source pulse taken as bit 0
    tfr_frame_gen #(
        .LEN_W      (LEN_W)
    ) u_gen (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .run        (gen_run),
        .lock_mode  (gen_lock),
        .ref_in     (frame_ref_pin_i),
        .frame_len  (cfg_q.frame_len),
        .bit_cnt_q  (bit_cnt),
        .frame_start(trib_frame_start),
        .ref_pulse_q(ref_pulse)
    );

    // [R5] drive only in output role
    assign frame_ref_pin_oe = (role_q == tfr_pkg::ROLE_REF_OUT);
    assign frame_ref_pin_o  = ref_pulse && frame_ref_pin_oe;

endmodule : tfr_pin_top
`default_nettype wire

// ### verif/tfr_pin_chk.sv
// port assertions for the shared pin block
`timescale 1ns/100ps
`default_nettype none
module tfr_pin_chk (
    input wire logic hclk,              // clock
    input wire logic hresetn,           // reset, active low
    input wire logic hreadyout,         // slave ready
    input wire logic hresp,             // response
    input wire logic frame_ref_pin_o,   // pin drive
    input wire logic frame_ref_pin_oe,  // pin enable
    input wire logic parity_mismatch_q, // parity fail
    input wire logic trib_frame_start   // frame bit 0
);
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    sequence ref_pulse_s;
        frame_ref_pin_oe && frame_ref_pin_o;
    endsequence
    sequence frame_next_s;
        ##1 trib_frame_start && !frame_ref_pin_o;
    endsequence
    bus_okay_a: assert property (hreadyout && hresp == tfr_pkg::HRESP_OKAY)
        else $error("bus not ready or not okay");
    drive_gated_a: assert property (!frame_ref_pin_oe |-> !frame_ref_pin_o)
        else $error("pin high while not driven");
    pulse_single_a: assert property (frame_ref_pin_o |=> !frame_ref_pin_o)
        else $error("reference pulse longer than one bit");
    pulse_then_start_a: assert property (ref_pulse_s |-> frame_next_s)
        else $error("no frame start after pulse");
    start_after_pulse_a: assert property (frame_ref_pin_oe && $past(frame_ref_pin_oe)
        && trib_frame_start |-> $past(frame_ref_pin_o))
        else $error("frame start without pulse before");
    start_low_a: assert property (frame_ref_pin_oe && trib_frame_start |-> !frame_ref_pin_o)
        else $error("pulse on frame bit 0");
    first_frame_a: assert property ($rose(frame_ref_pin_oe) |-> trib_frame_start)
        else $error("output role not starting at bit 0");
    no_parity_out_a: assert property (frame_ref_pin_oe && $past(frame_ref_pin_oe)
        |-> !parity_mismatch_q)
        else $error("parity checked in reference role");
endmodule : tfr_pin_chk
`default_nettype wire

// ### verif/tfr_src_model.sv
// far-side telecom bus and tributary source model
`timescale 1ns/100ps
`default_nettype none
module tfr_src_model (
    input  wire logic        hclk,    // clock
    input  wire logic        hresetn, // reset, active low
    input  wire logic [1:0]  mode,    // 0 toggling, 1 parity, 2 pulses
    input  wire logic        cov_flags, // parity takes flags too
    input  wire logic        odd,     // odd sense
    input  wire logic        bad,     // corrupt parity now
    input  wire logic [15:0] per,     // pulse period
    output var tfr_pkg::tfr_tbus_s tbus, // telecom data and flags
    output logic             pin,     // level offered on pin
    output logic             trib     // tributary bit
);
    logic [15:0] cnt_q, cnt_d;
    logic        tog_q, tog_d;
    always_comb begin
        cnt_d = cnt_q + 16'h1;
        tog_d = ~tog_q;
        if (mode == 2'h2 && cnt_q >= per - 16'h1) begin
            cnt_d = 16'h0;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 16'h0;
            tog_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tog_q <= tog_d;
        end
    end
    assign tbus = {cnt_q[7:0], cnt_q[2], cnt_q[4]};
    assign trib = cnt_q[1] ^ cnt_q[3];
    always_comb begin
        // released pin keeps changing so no stale level
        pin = tog_q;
        if (mode == 2'h1) begin
            pin = ^cnt_q[7:0] ^ (cov_flags & (cnt_q[2] ^ cnt_q[4])) ^ odd ^ bad;
        end
        // one-bit pulse with frame bit 0
        if (mode == 2'h2) begin
            pin = (cnt_q == 16'h0);
        end
    end
endmodule : tfr_src_model
`default_nettype wire

// ### verif/tfr_pin_tb_top.sv
// self-checking bench for the shared parity / frame reference pin
`timescale 1ns/100ps
`default_nettype none
module tfr_pin_tb_top;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0]  htrans = 2'h0, m_mode = 2'h0;
    logic [2:0]  hsize = 3'h0;
    logic        rdy, hresp, pin_o, oe, pin_i, m_pin, mism, fst, trib, tdq;
    logic        m_cover = 1'b0, m_odd = 1'b0, m_bad = 1'b0;
    logic [15:0] m_per = 16'h0006;
    tfr_pkg::tfr_tbus_s tbus;
    int          num_errors = 0, checked = 0;
    always #20 hclk = ~hclk;
    // device drive wins over the far side
    assign pin_i = oe ? pin_o : m_pin;
    tfr_pin_top u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(rdy), .hreadyout(rdy), .hrdata, .hresp, .telecom_tx_bus(tbus),
        .tributary_data_in(trib), .frame_ref_pin_i(pin_i), .frame_ref_pin_o(pin_o),
        .frame_ref_pin_oe(oe), .parity_mismatch_q(mism), .trib_frame_start(fst),
        .trib_data_q(tdq));
    tfr_src_model u_src (.hclk, .hresetn, .mode(m_mode), .cov_flags(m_cover), .odd(m_odd),
        .bad(m_bad), .per(m_per), .tbus(tbus), .pin(m_pin), .trib(trib));
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask : chk
    task bus(input logic [11:0] idx, input logic w, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {18'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= tfr_pkg::HSIZE_WORD;
        do @(posedge hclk); while (rdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (rdy !== 1'b1);
        rd = hrdata;
    endtask : bus
    task t_regs;
        bus(tfr_pkg::IDX_ICB1, 1'b0, 32'h0);
        chk(rd, {24'h0, tfr_pkg::ICB_RESET}, "icb reset");
        chk(hresp, tfr_pkg::HRESP_OKAY, "hresp okay");
        bus(tfr_pkg::IDX_CFG, 1'b0, 32'h0);
        chk(rd, {tfr_pkg::FRAME_LEN_RESET, 16'h0}, "cfg reset");
        bus(tfr_pkg::IDX_ICB1, 1'b1, 32'hFFFF_FFFF);
        bus(tfr_pkg::IDX_ICB1, 1'b0, 32'h0);
        chk(rd, 32'h3, "icb fields");
        bus(12'h0, 1'b1, 32'hFFFF_FFFF);
        bus(12'h0, 1'b0, 32'h0);
        chk(rd, 32'h0, "unmapped");
        $display("regs test done");
    endtask : t_regs
    task t_parity;
        for (int i = 0; i < 4; i++) begin
            bus(tfr_pkg::IDX_ICB1, 1'b1, i);
            m_cover <= i[0];
            m_odd <= i[1];
            m_mode <= 2'h1;
            // framer also on: bus enable must win
            bus(tfr_pkg::IDX_CFG, 1'b1, 32'h3);
            repeat (3) @(posedge hclk);
            repeat (8) begin
                @(negedge hclk);
                chk(mism, 1'b0, "mismatch good");
                chk(oe, 1'b0, "oe parity");
            end
            @(posedge hclk);
            m_bad <= 1'b1;
            @(posedge hclk);
            m_bad <= 1'b0;
            @(negedge hclk);
            chk(mism, 1'b1, "mismatch bad");
        end
        bus(tfr_pkg::IDX_STATUS, 1'b0, 32'h0);
        chk(rd[1:0], 2'h1, "role parity");
        m_mode <= 2'h0;
        $display("parity test done");
    endtask : t_parity
    task t_refout;
        int n;
        for (int t = 0; t < 2; t++) begin
            bus(tfr_pkg::IDX_CFG, 1'b1, 32'h0);
            bus(tfr_pkg::IDX_CFG, 1'b1, {16'h4, 10'h0, t[1:0], 4'h2});
            n = 0;
            repeat (3) @(posedge hclk);
            repeat (16) begin
                @(negedge hclk);
                n += pin_o;
                chk(oe, 1'b1, "oe ref out");
            end
            chk(n, 4, "pulses per 16 bits");
        end
        $display("ref out test done");
    endtask : t_refout
    task t_refin;
        int   n;
        logic tprev;
        n = 0;
        m_mode <= 2'h2;
        // flywheel length differs from pulse period
        bus(tfr_pkg::IDX_CFG, 1'b1, {16'h8, 10'h0, tfr_pkg::TM_PULSE, 4'h2});
        repeat (8) @(posedge hclk);
        @(negedge hclk);
        tprev = trib;
        repeat (18) begin
            @(negedge hclk);
            n += fst;
            if (pin_i === 1'b1) chk(fst, 1'b1, "start on pulse");
            chk(oe, 1'b0, "oe ref in");
            chk(tdq, tprev, "trib delay");
            tprev = trib;
        end
        chk(n, 3, "frames per 18 bits");
        $display("ref in test done");
    endtask : t_refin
    task t_bypass;
        for (int t = 0; t < 3; t += 2) begin
            bus(tfr_pkg::IDX_CFG, 1'b1, {16'h4, 10'h0, t[1:0], 4'h6});
            repeat (10) begin
                @(negedge hclk);
                chk(oe, 1'b0, "oe bypass");
            end
            bus(tfr_pkg::IDX_STATUS, 1'b0, 32'h0);
            chk(rd & 32'hFFFF_0003, 32'h0, "role and count");
        end
        $display("bypass test done");
    endtask : t_bypass
    task stop_test;
        $display("checks %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_parity();
        t_refout();
        t_refin();
        t_bypass();
        stop_test();
    end
    // run needs about 210 cycles
    initial begin
        repeat (5000) @(posedge hclk);
        num_errors++;
        stop_test();
    end
endmodule : tfr_pin_tb_top
bind tfr_pin_top tfr_pin_chk u_chk (.hclk, .hresetn, .hreadyout, .hresp, .frame_ref_pin_o,
    .frame_ref_pin_oe, .parity_mismatch_q, .trib_frame_start);
`default_nettype wire
